//--- rtl/pcstk_defs.svh
/*
 * Register offsets, field positions, reset values and sizes for the
 * program counter and return stack block.
 * Assumes inclusion by its bare name from the package and the design.
 */
`ifndef PCSTK_DEFS_SVH
`define PCSTK_DEFS_SVH

// ****************************************************************
// Register byte addresses on the AXI4-Lite slave
// ****************************************************************
`define OFS_PC_LOW        12'h000
`define OFS_HIGH_LATCH    12'h004
`define OFS_UPPER_LATCH   12'h008
`define OFS_TOS_LOW       12'h00C
`define OFS_TOS_HIGH      12'h010
`define OFS_TOS_UPPER     12'h014
`define OFS_STACK_PTR     12'h018
`define OFS_PWR_STATUS    12'h01C
`define OFS_STACK_CTRL    12'h020

// ****************************************************************
// Sizes and fields
// ****************************************************************
`define PC_W              21
`define SP_W              6
`define STK_DEPTH_NORM    6'h1F
`define STK_DEPTH_DBG     6'h23
`define SP_RESET          6'h00
`define PC_RESET          21'h000000
`define PC_STEP           21'h000002
`define STAT_FULL_BIT     0
`define STAT_OVF_BIT      1
`define STAT_UNF_BIT      2
`define CTRL_PUSH_BIT     0
`define CTRL_POP_BIT      1
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

//--- rtl/pcstk_pkg.sv
/*
 * Types shared by the program counter and return stack block.
 * Assumes the constants header is on the include path.
 */
`include "pcstk_defs.svh"

package pcstk_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_STEP,
        OP_JUMP,
        OP_CALL,
        OP_IRQ,
        OP_RETURN
    } core_op_t;

    typedef struct packed {
        core_op_t                op;
        logic [`PC_W-1:0]        target;
    } core_req_t;

    typedef struct packed {
        logic                    full;
        logic                    overflow;
        logic                    underflow;
    } stack_status_t;

endpackage

//--- rtl/program_counter_return_stack.sv
/*
 * Program counter with byte latches and a hardware return stack,
 * reachable by software over an AXI4-Lite slave.
 * Assumes the core decoder issues one operation per cycle on core_req,
 * and that software keeps interrupts off while it touches the stack.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pcstk_defs.svh"

module program_counter_return_stack (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire pcstk_pkg::core_req_t      core_req,
    input  wire logic                      in_circuit_debug_mode,
    output logic [`PC_W-1:0]               program_counter,
    output pcstk_pkg::stack_status_t       stack_status,
    input  wire logic [11:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [11:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import pcstk_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [`PC_W-1:0]  pc_r;
    logic [7:0]        high_byte_latch_r;
    logic [4:0]        upper_byte_latch_r;
    logic [`SP_W-1:0]  stack_pointer_r;

    // Pointer zero has no entry
    logic [`PC_W-1:0]  stack_mem_r [1:35];
    logic              full_r;
    logic              overflow_r;
    logic              underflow_r;

    logic              dbg_s1_r;
    logic              dbg_s2_r;

    logic [11:0]       awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_have_r;
    logic              w_have_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    // ****************************************************************
    // Debug mode strap synchroniser
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbg_s1_r <= 1'b0;
            dbg_s2_r <= 1'b0;
        end else begin
            // Pin is asynchronous to aclk
            dbg_s1_r <= in_circuit_debug_mode;
            dbg_s2_r <= dbg_s1_r;
        end
    end

    // ****************************************************************
    // Bus write channel capture
    // ****************************************************************
    logic wr_go;
    logic rd_go;
    logic aw_hit;
    logic w_hit;

    // Halves are taken in either order
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;

    assign aw_hit        = s_axi_awvalid && s_axi_awready;
    assign w_hit         = s_axi_wvalid && s_axi_wready;

    // Commit once both halves are held
    assign wr_go         = aw_have_r && w_have_r && !bvalid_r;

    assign s_axi_arready = !rvalid_r;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end else begin
            if (aw_hit) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end

            if (w_hit) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Write decode
    // ****************************************************************
    logic       wen;
    logic [7:0] wbyte;
    logic       wr_pcl;
    logic       wr_lath;
    logic       wr_latu;
    logic       wr_top_entry_low;
    logic       wr_top_entry_high;
    logic       wr_top_entry_upper;
    logic       wr_sp;
    logic       wr_stat;
    logic       wr_ctrl;
    logic       wr_known;

    // Registers use byte lane 0 only
    assign wen      = wr_go && wstrb_r[0];
    assign wbyte    = wdata_r[7:0];
    assign wr_pcl   = wen && (awaddr_r == `OFS_PC_LOW);
    assign wr_lath  = wen && (awaddr_r == `OFS_HIGH_LATCH);
    assign wr_latu  = wen && (awaddr_r == `OFS_UPPER_LATCH);
    assign wr_top_entry_low  = wen && (awaddr_r == `OFS_TOS_LOW);
    assign wr_top_entry_high  = wen && (awaddr_r == `OFS_TOS_HIGH);
    assign wr_top_entry_upper  = wen && (awaddr_r == `OFS_TOS_UPPER);
    assign wr_sp    = wen && (awaddr_r == `OFS_STACK_PTR);
    assign wr_stat  = wen && (awaddr_r == `OFS_PWR_STATUS);
    assign wr_ctrl  = wen && (awaddr_r == `OFS_STACK_CTRL);

    // Unmapped offsets: error, no effect
    assign wr_known = (awaddr_r == `OFS_PC_LOW)    || (awaddr_r == `OFS_HIGH_LATCH) ||
                      (awaddr_r == `OFS_UPPER_LATCH) || (awaddr_r == `OFS_TOS_LOW) ||
                      (awaddr_r == `OFS_TOS_HIGH)  || (awaddr_r == `OFS_TOS_UPPER) ||
                      (awaddr_r == `OFS_STACK_PTR) || (awaddr_r == `OFS_PWR_STATUS) ||
                      (awaddr_r == `OFS_STACK_CTRL);

    // ****************************************************************
    // Stack push and pop arbitration
    // ****************************************************************
    logic [`SP_W-1:0] depth;
    logic             core_push;
    logic             core_pop;
    logic             do_push;
    logic             do_pop;
    logic             push_ok;
    logic             pop_ok;
    logic [`PC_W-1:0] tos_val;
    logic             rd_pcl;

    assign depth     = dbg_s2_r ? `STK_DEPTH_DBG : `STK_DEPTH_NORM;

    assign core_push = (core_req.op == OP_CALL) || (core_req.op == OP_IRQ);
    assign core_pop  = (core_req.op == OP_RETURN);

    // Push wins over pop
    assign do_push   = core_push || (wr_ctrl && wbyte[`CTRL_PUSH_BIT]);
    assign do_pop    = !do_push && (core_pop || (wr_ctrl && wbyte[`CTRL_POP_BIT]));

    // No write beyond the last entry
    assign push_ok   = do_push && (stack_pointer_r < depth);
    assign pop_ok    = do_pop && (stack_pointer_r != `SP_RESET);

    // Empty stack reads as zero
    assign tos_val   = (stack_pointer_r == `SP_RESET) ? `PC_RESET : stack_mem_r[stack_pointer_r];

    assign rd_pcl    = rd_go && (s_axi_araddr == `OFS_PC_LOW);

    // Private storage; no memory space maps here
    always_ff @(posedge aclk) begin
        if (push_ok) begin
            // Counter already points past the call
            stack_mem_r[stack_pointer_r + 6'h01] <= pc_r;
        end else if (stack_pointer_r != `SP_RESET) begin
            // Ignored while the stack is empty
            if (wr_top_entry_low) begin
                stack_mem_r[stack_pointer_r][7:0] <= {wbyte[7:1], 1'b0};
            end

            if (wr_top_entry_high) begin
                stack_mem_r[stack_pointer_r][15:8] <= wbyte;
            end

            if (wr_top_entry_upper) begin
                stack_mem_r[stack_pointer_r][20:16] <= wbyte[4:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stack_pointer_r <= `SP_RESET;
        end else if (push_ok) begin
            stack_pointer_r <= stack_pointer_r + 6'h01;
        end else if (pop_ok) begin
            stack_pointer_r <= stack_pointer_r - 6'h01;
        end else if (wr_sp) begin
            // Clamp to the depth in use
            stack_pointer_r <= (wbyte[5:0] > depth) ? depth : wbyte[5:0];
        end
    end

    // ****************************************************************
    // Stack status flags; overflow and underflow sticky until software writes one to clear, full follows the pointer
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_r  <= 1'b0;
            underflow_r <= 1'b0;
            full_r      <= 1'b0;
        end else begin
            // Set wins over clear
            overflow_r  <= (do_push && !push_ok) ||
                           (overflow_r && !(wr_stat && wbyte[`STAT_OVF_BIT]));

            underflow_r <= (do_pop && !pop_ok) ||
                           (underflow_r && !(wr_stat && wbyte[`STAT_UNF_BIT]));

            full_r      <= push_ok ? ((stack_pointer_r + 6'h01) == depth) :
                           pop_ok ? 1'b0 : (stack_pointer_r == depth);
        end
    end

    // ****************************************************************
    // Program counter and byte latches
    // ****************************************************************
    // Pop, then low-byte write, then core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_r <= `PC_RESET;
        end else if (pop_ok) begin
            pc_r <= {tos_val[20:1], 1'b0};
        end else if (wr_pcl) begin
            pc_r <= {upper_byte_latch_r, high_byte_latch_r, wbyte[7:1], 1'b0};
        end else begin
            case (core_req.op)
                OP_STEP: pc_r <= pc_r + `PC_STEP;
                OP_JUMP, OP_CALL, OP_IRQ: pc_r <= {core_req.target[20:1], 1'b0};
                default: pc_r <= pc_r;
            endcase
        end
    end

    // Latches move only on bus accesses, never on calls or returns
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_byte_latch_r  <= 8'h00;
            upper_byte_latch_r <= 5'h00;
        end else if (rd_pcl) begin
            // Low-byte read beats a latch write
            high_byte_latch_r  <= pc_r[15:8];
            upper_byte_latch_r <= pc_r[20:16];
        end else begin
            if (wr_lath) begin
                high_byte_latch_r <= wbyte;
            end

            if (wr_latu) begin
                upper_byte_latch_r <= wbyte[4:0];
            end
        end
    end

    // Outputs straight from flops
    assign program_counter    = pc_r;
    assign stack_status       = '{full: full_r, overflow: overflow_r, underflow: underflow_r};

    // ****************************************************************
    // Write response
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `AXI_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Stands until bready is seen
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [31:0] rd_mux;
    logic        rd_known;

    // Unused upper bits read zero
    always_comb begin
        rd_mux   = 32'h00000000;
        rd_known = 1'b1;
        case (s_axi_araddr)
            `OFS_PC_LOW:      rd_mux = {24'h000000, pc_r[7:0]};
            `OFS_HIGH_LATCH:  rd_mux = {24'h000000, high_byte_latch_r};
            `OFS_UPPER_LATCH: rd_mux = {27'h0000000, upper_byte_latch_r};
            `OFS_TOS_LOW:     rd_mux = {24'h000000, tos_val[7:0]};
            `OFS_TOS_HIGH:    rd_mux = {24'h000000, tos_val[15:8]};
            `OFS_TOS_UPPER:   rd_mux = {27'h0000000, tos_val[20:16]};
            `OFS_STACK_PTR:   rd_mux = {26'h0000000, stack_pointer_r};
            `OFS_PWR_STATUS:  rd_mux = {29'h00000000, underflow_r, overflow_r, full_r};
            `OFS_STACK_CTRL:  rd_mux = 32'h00000000;
            default:          rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `AXI_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Stands until rready is seen
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

endmodule
`default_nettype wire

//--- testbench/program_counter_return_stack_sva.sv
/* Port checker for the program counter and return stack block.
   Assumes a single aclk domain with synchronous active-low aresetn. */
`timescale 1ns/1ps
`default_nettype none
`include "pcstk_defs.svh"
module program_counter_return_stack_sva (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire pcstk_pkg::core_req_t     core_req,
    input wire logic [`PC_W-1:0]         program_counter,
    input wire pcstk_pkg::stack_status_t stack_status,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic                     s_axi_rvalid
);
    import pcstk_pkg::*;
    // ****************************************************************
    // No register write can commit in the cycle after a quiet one
    // ****************************************************************
    logic busy_r;
    logic quiet;
    always_ff @(posedge aclk) begin
        if (!aresetn) busy_r <= 1'b0;
        else busy_r <= s_axi_awvalid | s_axi_wvalid;
    end
    assign quiet = !s_axi_awvalid && !s_axi_wvalid && !busy_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_lsb;
        program_counter[0] == 1'b0;
    endproperty
    a_lsb: assert property (p_lsb) else $error("counter bit zero set");
    property p_step;
        core_req.op == OP_STEP && quiet |=> program_counter == $past(program_counter) + 21'h000002;
    endproperty
    a_step: assert property (p_step) else $error("step did not add two");
    property p_jump;
        core_req.op == OP_JUMP && quiet |=> program_counter == {$past(core_req.target[20:1]), 1'b0};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not loaded");
    property p_call;
        (core_req.op == OP_CALL || core_req.op == OP_IRQ) && quiet && !stack_status.full
            |=> program_counter == {$past(core_req.target[20:1]), 1'b0};
    endproperty
    a_call: assert property (p_call) else $error("call target not loaded");
    property p_rst;
        $rose(aresetn) |-> program_counter == '0 && stack_status == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_bbusy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bbusy: assert property (p_bbusy) else $error("write accepted while response pending");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read data late");
    property p_rbusy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rbusy: assert property (p_rbusy) else $error("read accepted while data pending");
    property p_ovf;
        stack_status.overflow && quiet |=> stack_status.overflow;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
    property p_unf;
        stack_status.underflow && quiet |=> stack_status.underflow;
    endproperty
    a_unf: assert property (p_unf) else $error("underflow flag dropped");
    property p_ovfull;
        $rose(stack_status.overflow) |-> stack_status.full;
    endproperty
    a_ovfull: assert property (p_ovfull) else $error("overflow without full stack");
endmodule
bind program_counter_return_stack program_counter_return_stack_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .core_req(core_req), .program_counter(program_counter),
    .stack_status(stack_status), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

//--- testbench/core_model.sv
/* Instruction decoder model driving one core operation per call.
   Assumes the bench calls issue from one process only. */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic               aclk,
    output var pcstk_pkg::core_req_t core_req
);
    import pcstk_pkg::*;
    // ****************************************************************
    // Operation held for one edge, then idle with a changed target
    // ****************************************************************
    initial core_req = '{OP_NONE, 21'h000000};
    task automatic issue(input core_op_t op, input logic [20:0] t, input int gap);
        @(posedge aclk);
        core_req <= '{op, t};
        @(posedge aclk);
        core_req <= '{OP_NONE, ~t};
        repeat (gap) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

//--- testbench/program_counter_return_stack_tb.sv
/* Self-checking bench for the program counter and return stack.
   Assumes the core model and an AXI4-Lite master task set drive it. */
`timescale 1ns/1ps
`default_nettype none
`include "pcstk_defs.svh"
module program_counter_return_stack_tb;
    import pcstk_pkg::*;
    logic          aclk, aresetn, dbg;
    core_req_t     core_req;
    stack_status_t st;
    logic [20:0]   pc, exp_pc, t, lat;
    logic [20:0]   stk[$];
    logic [11:0]   awaddr, araddr;
    logic [31:0]   wdata, rdata, rd;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, rs;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready;
    int            num_errors, num_checks, seed, i;
    program_counter_return_stack DUT (
        .aclk(aclk), .aresetn(aresetn), .core_req(core_req), .in_circuit_debug_mode(dbg),
        .program_counter(pc), .stack_status(st), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    core_model u_core (.aclk(aclk), .core_req(core_req));
    // ****************************************************************
    // Expectations, bus master and verdict
    // ****************************************************************
    function automatic logic [20:0] ld(input logic [20:0] a);
        return {a[20:1], 1'b0};
    endfunction
    function automatic logic [20:0] prog_ctr_low_byte(input logic [4:0] u, input logic [7:0] h, input logic [7:0] l);
        return {u, h, l[7:1], 1'b0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Wait until the selected ready or valid is sampled high, capturing the answer
    task automatic hold(input int k);
        logic s;
        do begin
            @(negedge aclk);
            s = (k == 0) ? arready : (k == 1) ? rvalid : bvalid;
            rd = rdata;
            rs = bvalid ? bresp : rresp;
        end while (s !== 1'b1);
        @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        hold(2);
        bready <= 1'b0;
    endtask
    task automatic rdt(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hold(0);
        arvalid <= 1'b0;
        hold(1);
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rdt(a);
        chk(rd, e);
    endtask
    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        #(20000 * 100);
        num_errors++;
        close_out();
    end
    initial begin
        seed = 98456;
        aresetn = 1'b0;
        dbg = 1'b0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        num_errors = 0;
        num_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFS_STACK_PTR, 32'h0);
        rchk(`OFS_PWR_STATUS, 32'h0);
        exp_pc = '0;
        for (i = 0; i < 24; i++) begin
            t = 21'($random(seed));
            if (t[0]) begin
                u_core.issue(OP_JUMP, t, i % 3);
                exp_pc = ld(t);
            end else begin
                u_core.issue(OP_STEP, t, i % 3);
                exp_pc = exp_pc + 21'h000002;
            end
            #1;
            chk(32'(pc), 32'(exp_pc));
        end
        lat = 21'($random(seed));
        wr(`OFS_HIGH_LATCH, 32'(lat[15:8]));
        wr(`OFS_UPPER_LATCH, 32'(lat[20:16]));
        rchk(`OFS_UPPER_LATCH, 32'(lat[20:16]));
        wr(`OFS_PC_LOW, {24'h0, lat[7:0] | 8'h01});
        chk(32'(pc), 32'(prog_ctr_low_byte(lat[20:16], lat[15:8], lat[7:0])));
        lat = 21'($random(seed));
        u_core.issue(OP_JUMP, lat, 0);
        rchk(`OFS_PC_LOW, 32'({lat[7:1], 1'b0}));
        rchk(`OFS_HIGH_LATCH, 32'(lat[15:8]));
        rchk(`OFS_UPPER_LATCH, 32'(lat[20:16]));
        // Core stays idle whenever software touches the stack
        stk.delete();
        for (i = 0; i < 32; i++) begin
            if (i < 31) stk.push_back(pc);
            t = 21'($random(seed));
            u_core.issue(t[1] ? OP_IRQ : OP_CALL, t, i % 2);
            #1;
            if (i < 31) chk(32'(pc), 32'(ld(t)));
        end
        rchk(`OFS_STACK_PTR, 32'd31);
        rchk(`OFS_PWR_STATUS, 32'h3);
        chk(32'(st), 32'h6);
        rchk(`OFS_TOS_LOW, 32'(stk[$][7:0]));
        rchk(`OFS_TOS_UPPER, 32'(stk[$][20:16]));
        wstrb <= 4'h0;
        wr(`OFS_HIGH_LATCH, 32'(~lat[15:8]));
        wstrb <= 4'hF;
        chk(32'(rs), 32'(`AXI_OKAY));
        rchk(`OFS_HIGH_LATCH, 32'(lat[15:8]));
        wr(`OFS_TOS_HIGH, 32'h000000A5);
        stk[$][15:8] = 8'hA5;
        rchk(`OFS_TOS_HIGH, 32'h000000A5);
        for (i = 0; i < 32; i++) begin
            exp_pc = (i < 31) ? stk.pop_back() : pc;
            u_core.issue(OP_RETURN, 21'h000000, i % 2);
            #1;
            chk(32'(pc), 32'(exp_pc));
        end
        rchk(`OFS_PWR_STATUS, 32'h6);
        chk(32'(st), 32'h3);
        rchk(`OFS_TOS_LOW, 32'h0);
        rchk(`OFS_UPPER_LATCH, 32'(lat[20:16]));
        wr(`OFS_PWR_STATUS, 32'h6);
        rchk(`OFS_PWR_STATUS, 32'h0);
        exp_pc = pc;
        wr(`OFS_STACK_CTRL, 32'h1);
        rchk(`OFS_STACK_PTR, 32'h1);
        rchk(`OFS_TOS_LOW, 32'(exp_pc[7:0]));
        u_core.issue(OP_JUMP, ~exp_pc, 0);
        wr(`OFS_STACK_CTRL, 32'h2);
        chk(32'(pc), 32'(exp_pc));
        wr(`OFS_STACK_PTR, 32'h3F);
        rchk(`OFS_STACK_PTR, 32'd31);
        dbg <= 1'b1;
        repeat (3) @(posedge aclk);
        wr(`OFS_STACK_PTR, 32'h3F);
        rchk(`OFS_STACK_PTR, 32'h23);
        wr(12'h040, 32'h0);
        chk(32'(rs), 32'(`AXI_SLVERR));
        rdt(12'h044);
        chk(32'(rs), 32'(`AXI_SLVERR));
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFS_STACK_PTR, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
